// [pkg/mailbox_pkg.sv]
// shared constants and types for the controller mailbox
// assumes a 125 MHz core clock and a free-running link sample clock
package mailbox_pkg;
   // bus slave address, seven bits, and the direction bit value for reads
   localparam logic [6:0] SLAVE_ADDR = 7'h38;
   localparam logic RW_READ = 1'h1;
   // last bit index inside one serial byte
   localparam logic [2:0] BIT_LAST = 3'h7;
   // write data byte positions: start address, low byte, high byte
   localparam logic [1:0] WR_IDX_ADDR = 2'h0;
   localparam logic [1:0] WR_IDX_LO = 2'h1;
   localparam logic [1:0] WR_IDX_HI = 2'h2;
   // host message length and index of its last byte
   localparam int HOST_BYTES = 4;
   localparam logic [1:0] HOST_IDX_LAST = 2'h3;
   // idle level returned when nothing is pending
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   // report byte 0 flag position and empty byte
   localparam int FROM_CTRL_BIT = 7;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // word buffer shape
   localparam int WORD_W = 16;
   localparam int FIFO_DEPTH = 16;
   // report polling interval
   localparam int CLK_HZ = 125000000;
   localparam int POLL_MS = 32;
   localparam int POLL_CYCLES = POLL_MS * (CLK_HZ / 1000);
   // one controller word, low byte first on the wire
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } ctrl_word_t;
   // three-byte input report toward the host
   typedef struct packed {
      logic [7:0] byte2;
      logic [7:0] byte1;
      logic [7:0] byte0;
   } in_report_t;
   // four host bytes, index 0 sent first
   typedef logic [HOST_BYTES-1:0][7:0] host_msg_t;
   // link state machine, one-hot
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_ADDR_ACK = 7'h04,
      ST_WR_BYTE = 7'h08,
      ST_WR_ACK = 7'h10,
      ST_RD_BYTE = 7'h20,
      ST_RD_ACK = 7'h40
   } link_state_t;
endpackage

// [logic/bit_sync.sv]
// two-flop level synchroniser, one stage pair per bit
// assumes inputs come from another clock domain or a pin
`timescale 1ns/1ns
module bit_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_reg; // first stage, read only by second
   // two stages, cleared under reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= '0;
         q_o <= '0;
      end else begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule

// [logic/word_fifo.sv]
// synchronous word buffer with valid/ready on both sides
// assumes one clock for filling and draining
`timescale 1ns/1ns
module word_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH]; // storage
   logic [AW-1:0] wr_ptr_reg; // next write slot
   logic [AW-1:0] rd_ptr_reg; // next read slot
   logic [AW:0] count_reg; // words held
   wire push = in_valid_i & in_ready_o;
   wire pop = out_valid_o & out_ready_i;
   // honest flags from the count
   assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (count_reg != '0);
   assign out_data_o = mem[rd_ptr_reg];
   // storage write
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end
   // pointers and count
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         wr_ptr_reg <= push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
         rd_ptr_reg <= pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
         count_reg <= (AW+1)'(count_reg + push - pop);
      end
   end
endmodule

// [logic/mcu_two_wire_mailbox.sv]
// two-wire slave mailbox between an external controller and the host
// link side oversamples the serial pins on link_clk_i; core on clk_i
// assumes link_clk_i runs free and at least 8x the serial clock rate
`timescale 1ns/1ns
// Overview of operation
// - slave only; two bytes in, four out
// - controller words go out in polled reports
// - host message raises pending notification output
// - clock input only; data line open-drain
// - data changes only while serial clock low
// - nine-th bit acknowledges each byte
// - respond only to the fixed slave address
// - first byte start address, next two stored; low byte refused while busy
// - read returns four bytes in sequence
// - report byte 0 flags controller data
module mcu_two_wire_mailbox #(
   parameter int POLL_CYCLES = mailbox_pkg::POLL_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic link_clk_i,
   input wire logic serial_clock_i,
   input wire logic serial_data_line_i,
   output logic serial_data_line_o,
   output logic serial_data_line_oe_o,
   output logic report_valid_o,
   input wire logic report_ready_i,
   output mailbox_pkg::in_report_t report_o,
   input wire logic host_valid_i,
   output logic host_ready_o,
   input wire mailbox_pkg::host_msg_t host_msg_i,
   output logic host_data_pending_flag_o
);
   // ---------------- reset release per domain ----------------
   logic [1:0] core_rst_reg; // core reset release chain
   logic [1:0] link_rst_reg; // link reset release chain
   wire core_rst_n = core_rst_reg[1];
   wire link_rst_n = link_rst_reg[1];
   // core reset: asserted at once, released after two edges
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         core_rst_reg <= 2'h0;
      end else begin
         core_rst_reg <= {core_rst_reg[0], 1'b1};
      end
   end
   // link reset: same scheme on the link clock
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         link_rst_reg <= 2'h0;
      end else begin
         link_rst_reg <= {link_rst_reg[0], 1'b1};
      end
   end

   // ---------------- core domain ----------------
   logic pending_reg; // host bytes waiting for the controller
   mailbox_pkg::host_msg_t msg_reg; // held host bytes
   logic wr_seen_reg; // last write toggle taken into the buffer
   logic done_seen_reg; // last read-done toggle handled
   logic [31:0] poll_cnt_reg; // report interval counter
   logic rep_valid_reg; // report offered to the host
   mailbox_pkg::in_report_t rep_reg; // report contents
   logic wr_tgl_core; // write toggle seen in core domain
   logic done_tgl_core; // read-done toggle seen in core domain
   logic fifo_in_ready; // buffer has room
   logic fifo_out_valid; // buffer holds a word
   mailbox_pkg::ctrl_word_t fifo_out; // oldest word

   // link-side registers read across the boundary
   logic wr_tgl_reg; // flips when a word is complete
   logic done_tgl_reg; // flips when the byte at index 3 was read while pending
   mailbox_pkg::ctrl_word_t word_reg; // controller word, stable while busy

   // handshake decode in the core domain
   wire wr_new = wr_tgl_core ^ wr_seen_reg;
   wire wr_push = wr_new & fifo_in_ready;
   wire done_new = done_tgl_core ^ done_seen_reg;
   wire poll_tick = (poll_cnt_reg == 32'(POLL_CYCLES - 1));
   wire rep_take = rep_valid_reg & report_ready_i;
   wire rep_load = poll_tick & ~rep_valid_reg;
   wire fifo_pop = rep_load & fifo_out_valid;
   wire host_take = host_valid_i & host_ready_o;

   // link toggles into the core clock
   bit_sync #(.W(2)) u_core_sync (
      .clk_i(clk_i),
      .rst_n_i(core_rst_n),
      .d_i({wr_tgl_reg, done_tgl_reg}),
      .q_o({wr_tgl_core, done_tgl_core})
   );

   // controller words wait here until a report carries them
   word_fifo #(
      .W(mailbox_pkg::WORD_W),
      .DEPTH(mailbox_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_n_i(core_rst_n),
      .in_valid_i(wr_new),
      .in_ready_o(fifo_in_ready),
      .in_data_i(word_reg),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_out)
   );

   // host side accepts a message only when the last one was read
   assign host_ready_o = ~pending_reg;
   assign host_data_pending_flag_o = pending_reg;
   assign report_valid_o = rep_valid_reg;
   assign report_o = rep_reg;

   // host message hold and pending notification
   always_ff @(posedge clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         pending_reg <= 1'b0;
         msg_reg <= '0;
         done_seen_reg <= 1'b0;
      end else begin
         done_seen_reg <= done_tgl_core;
         if (host_take) begin
            pending_reg <= 1'b1;
            msg_reg <= host_msg_i;
         end else if (done_new) begin
            pending_reg <= 1'b0;
         end
      end
   end

   // word acceptance; the toggle is returned only once buffered
   always_ff @(posedge clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         wr_seen_reg <= 1'b0;
      end else if (wr_push) begin
         wr_seen_reg <= wr_tgl_core;
      end
   end

   // fixed-interval report poll counter
   always_ff @(posedge clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         poll_cnt_reg <= '0;
      end else begin
         poll_cnt_reg <= poll_tick ? '0 : 32'(poll_cnt_reg + 1'b1);
      end
   end

   // report build: one buffered word per interval
   always_ff @(posedge clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         rep_valid_reg <= 1'b0;
         rep_reg <= '0;
      end else if (rep_load) begin
         rep_valid_reg <= 1'b1;
         rep_reg.byte0 <= mailbox_pkg::ZERO_BYTE;
         rep_reg.byte0[mailbox_pkg::FROM_CTRL_BIT] <= fifo_out_valid;
         rep_reg.byte1 <= fifo_out_valid ? fifo_out.lo : mailbox_pkg::ZERO_BYTE;
         rep_reg.byte2 <= fifo_out_valid ? fifo_out.hi : mailbox_pkg::ZERO_BYTE;
      end else if (rep_take) begin
         rep_valid_reg <= 1'b0;
      end
   end

   // ---------------- link domain ----------------
   mailbox_pkg::link_state_t state_reg; // bus state
   logic scl_s; // synchronised serial clock
   logic sda_s; // synchronised data line
   logic scl_q; // previous serial clock sample
   logic sda_q; // previous data sample
   logic pending_s; // pending level in link domain
   logic ack_s; // buffer-accept toggle in link domain
   logic [7:0] shift_reg; // byte shifter
   logic [2:0] bit_cnt_reg; // bit index within byte
   logic byte_done_reg; // eighth bit received
   logic rw_reg; // direction of this transaction
   logic [1:0] wr_idx_reg; // data byte count in a write
   logic [1:0] ptr_reg; // start register address
   logic drive_low_reg; // pulls the data line low
   logic nacked_reg; // last byte refused

   // pins and core flags into the link clock, two flops each
   bit_sync #(.W(4)) u_link_sync (
      .clk_i(link_clk_i),
      .rst_n_i(link_rst_n),
      .d_i({serial_clock_i, serial_data_line_i, pending_reg, wr_seen_reg}),
      .q_o({scl_s, sda_s, pending_s, ack_s})
   );

   // bus condition decode from synchronised samples
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_cond = scl_s & scl_q & ~sda_q & sda_s;
   wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
   wire addr_hit = (shift_reg[7:1] == mailbox_pkg::SLAVE_ADDR);
   wire busy = wr_tgl_reg ^ ack_s;
   wire [7:0] tx_byte = pending_s ? msg_reg[ptr_reg] : mailbox_pkg::IDLE_BYTE;
   wire wr_ok = (wr_idx_reg == mailbox_pkg::WR_IDX_ADDR) |
                ((wr_idx_reg == mailbox_pkg::WR_IDX_LO) & ~busy) |
                (wr_idx_reg == mailbox_pkg::WR_IDX_HI);
   wire last_rd = (ptr_reg == mailbox_pkg::HOST_IDX_LAST);
   // next byte for a continued read, address wraps at four
   wire [1:0] ptr_next = 2'(ptr_reg + 1'b1);
   wire [7:0] msg_next = pending_s ? msg_reg[ptr_next] : mailbox_pkg::IDLE_BYTE;

   // open drain: only ever drives low
   assign serial_data_line_o = 1'b0;
   assign serial_data_line_oe_o = drive_low_reg;

   // previous samples for edge detection
   always_ff @(posedge link_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   // bit-level slave state machine
   always_ff @(posedge link_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         state_reg <= mailbox_pkg::ST_IDLE;
         shift_reg <= '0;
         bit_cnt_reg <= '0;
         byte_done_reg <= 1'b0;
         rw_reg <= 1'b0;
         wr_idx_reg <= '0;
         ptr_reg <= '0;
         drive_low_reg <= 1'b0;
         nacked_reg <= 1'b0;
         wr_tgl_reg <= 1'b0;
         done_tgl_reg <= 1'b0;
         word_reg <= '0;
      end else if (start_cond) begin
         // start or repeated start restarts address phase
         state_reg <= mailbox_pkg::ST_ADDR;
         bit_cnt_reg <= '0;
         byte_done_reg <= 1'b0;
         wr_idx_reg <= '0;
         drive_low_reg <= 1'b0;
      end else if (stop_cond) begin
         state_reg <= mailbox_pkg::ST_IDLE;
         drive_low_reg <= 1'b0;
      end else begin
         case (state_reg)
            // sample eight bits on rising edges
            mailbox_pkg::ST_ADDR,
            mailbox_pkg::ST_WR_BYTE: begin
               if (scl_rise) begin
                  shift_reg <= rx_byte;
                  bit_cnt_reg <= 3'(bit_cnt_reg + 1'b1);
                  byte_done_reg <= (bit_cnt_reg == mailbox_pkg::BIT_LAST);
               end else if (scl_fall && byte_done_reg) begin
                  byte_done_reg <= 1'b0;
                  if (state_reg == mailbox_pkg::ST_ADDR) begin
                     // only the own address is acknowledged
                     if (addr_hit) begin
                        drive_low_reg <= 1'b1;
                        rw_reg <= (shift_reg[0] == mailbox_pkg::RW_READ);
                        state_reg <= mailbox_pkg::ST_ADDR_ACK;
                     end else begin
                        state_reg <= mailbox_pkg::ST_IDLE;
                     end
                  end else begin
                     // address, low, high; extra bytes and a low byte while busy refused
                     drive_low_reg <= wr_ok;
                     nacked_reg <= ~wr_ok;
                     state_reg <= mailbox_pkg::ST_WR_ACK;
                     if (wr_idx_reg == mailbox_pkg::WR_IDX_ADDR) begin
                        ptr_reg <= shift_reg[1:0];
                     end else if (wr_ok && wr_idx_reg == mailbox_pkg::WR_IDX_LO) begin
                        word_reg.lo <= shift_reg;
                     end else if (wr_idx_reg == mailbox_pkg::WR_IDX_HI) begin
                        word_reg.hi <= shift_reg;
                        wr_tgl_reg <= ~wr_tgl_reg;
                     end
                     if (wr_ok) begin
                        wr_idx_reg <= 2'(wr_idx_reg + 1'b1);
                     end
                  end
               end
            end
            // after the acknowledge clock release, or drive the first read bit
            mailbox_pkg::ST_ADDR_ACK: begin
               if (scl_fall) begin
                  bit_cnt_reg <= '0;
                  if (rw_reg) begin
                     shift_reg <= tx_byte;
                     drive_low_reg <= ~tx_byte[7];
                     state_reg <= mailbox_pkg::ST_RD_BYTE;
                  end else begin
                     drive_low_reg <= 1'b0;
                     state_reg <= mailbox_pkg::ST_WR_BYTE;
                  end
               end
            end
            // after a refusal wait for stop or restart
            mailbox_pkg::ST_WR_ACK: begin
               if (scl_fall) begin
                  drive_low_reg <= 1'b0;
                  bit_cnt_reg <= '0;
                  state_reg <= nacked_reg ? mailbox_pkg::ST_IDLE : mailbox_pkg::ST_WR_BYTE;
               end
            end
            // shift bits out, changing only on falling edges
            mailbox_pkg::ST_RD_BYTE: begin
               if (scl_fall) begin
                  bit_cnt_reg <= 3'(bit_cnt_reg + 1'b1);
                  shift_reg <= {shift_reg[6:0], 1'b0};
                  if (bit_cnt_reg == mailbox_pkg::BIT_LAST) begin
                     drive_low_reg <= 1'b0;
                     state_reg <= mailbox_pkg::ST_RD_ACK;
                  end else begin
                     drive_low_reg <= ~shift_reg[6];
                  end
               end
            end
            // controller acknowledge decides the next byte
            mailbox_pkg::ST_RD_ACK: begin
               if (scl_rise) begin
                  nacked_reg <= sda_s;
                  if (last_rd && pending_s) begin
                     done_tgl_reg <= ~done_tgl_reg;
                  end
               end else if (scl_fall) begin
                  bit_cnt_reg <= '0;
                  if (nacked_reg) begin
                     state_reg <= mailbox_pkg::ST_IDLE;
                  end else begin
                     ptr_reg <= 2'(ptr_reg + 1'b1);
                     shift_reg <= msg_next;
                     drive_low_reg <= ~msg_next[7];
                     state_reg <= mailbox_pkg::ST_RD_BYTE;
                  end
               end
            end
            // idle: ignore everything but start
            default: begin
               drive_low_reg <= 1'b0;
               state_reg <= mailbox_pkg::ST_IDLE;
            end
         endcase
      end
   end
endmodule

// [test/mailbox_properties.sv]
// port assertions for the controller mailbox
// assumes binding onto mcu_two_wire_mailbox and the mailbox package
`timescale 1ns/1ns
module mailbox_properties #(
   parameter int POLL_CYCLES = 200
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic link_clk_i,
   input wire logic serial_clock_i,
   input wire logic serial_data_line_o,
   input wire logic serial_data_line_oe_o,
   input wire logic report_valid_o,
   input wire logic report_ready_i,
   input wire mailbox_pkg::in_report_t report_o,
   input wire logic host_valid_i,
   input wire logic host_ready_o,
   input wire logic host_data_pending_flag_o
);
   logic [31:0] gap_reg; // cycles since the last offer began
   logic [31:0] low_reg; // cycles with no report offered
   logic seen_reg; // valid as sampled last edge
   // interval counters for the polled report
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gap_reg <= 32'h0;
         low_reg <= 32'h0;
         seen_reg <= 1'b0;
      end else begin
         gap_reg <= (report_valid_o && !seen_reg) ? 32'h0 : gap_reg + 32'h1;
         low_reg <= report_valid_o ? 32'h0 : low_reg + 32'h1;
         seen_reg <= report_valid_o;
      end
   end
   // host message accepted, then pending and refusing
   sequence s_take;
      host_valid_i && host_ready_o;
   endsequence
   sequence s_pending_on;
      host_data_pending_flag_o && !host_ready_o;
   endsequence
   // serial clock held high for a while
   sequence s_clock_high;
      serial_clock_i [*4];
   endsequence
   property p_poll_gap;
      @(posedge clk_i) disable iff (!rst_n_i)
      (report_valid_o && !seen_reg) |-> gap_reg >= POLL_CYCLES - 1;
   endproperty
   a_poll_gap: assert property (p_poll_gap) else $error("report offered too soon");
   property p_poll_due;
      @(posedge clk_i) disable iff (!rst_n_i)
      low_reg < POLL_CYCLES + 8;
   endproperty
   a_poll_due: assert property (p_poll_due) else $error("report interval missed");
   property p_rep_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
      report_valid_o && !report_ready_i |=> report_valid_o && $stable(report_o);
   endproperty
   a_rep_hold: assert property (p_rep_hold) else $error("report not held");
   property p_rep_drop;
      @(posedge clk_i) disable iff (!rst_n_i)
      report_valid_o && report_ready_i |=> !report_valid_o;
   endproperty
   a_rep_drop: assert property (p_rep_drop) else $error("report not withdrawn");
   property p_rep_flag;
      @(posedge clk_i) disable iff (!rst_n_i)
      report_valid_o && !report_o.byte0[7] |-> report_o.byte1 == 8'h00 && report_o.byte2 == 8'h00;
   endproperty
   a_rep_flag: assert property (p_rep_flag) else $error("data without source flag");
   property p_pend_set;
      @(posedge clk_i) disable iff (!rst_n_i)
      s_take |=> s_pending_on;
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("pending not raised");
   property p_pend_cause;
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(host_data_pending_flag_o) |-> $past(host_valid_i && host_ready_o);
   endproperty
   a_pend_cause: assert property (p_pend_cause) else $error("pending without message");
   property p_ready_inv;
      @(posedge clk_i) disable iff (!rst_n_i)
      host_ready_o != host_data_pending_flag_o;
   endproperty
   a_ready_inv: assert property (p_ready_inv) else $error("ready while pending");
   property p_sdo_low;
      @(posedge link_clk_i) disable iff (!rst_n_i)
      serial_data_line_o == 1'b0;
   endproperty
   a_sdo_low: assert property (p_sdo_low) else $error("data line driven high");
   property p_data_steady;
      @(posedge link_clk_i) disable iff (!rst_n_i)
      s_clock_high |-> $stable(serial_data_line_oe_o);
   endproperty
   a_data_steady: assert property (p_data_steady) else $error("data moved, clock high");
endmodule
bind mcu_two_wire_mailbox mailbox_properties #(.POLL_CYCLES(POLL_CYCLES)) u_mailbox_properties (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
   .serial_clock_i(serial_clock_i), .serial_data_line_o(serial_data_line_o),
   .serial_data_line_oe_o(serial_data_line_oe_o), .report_valid_o(report_valid_o),
   .report_ready_i(report_ready_i), .report_o(report_o), .host_valid_i(host_valid_i),
   .host_ready_o(host_ready_o), .host_data_pending_flag_o(host_data_pending_flag_o)
);

// [test/mcu_master_model.sv]
// behavioural two-wire bus master in the controller's place
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ns
module mcu_master_model #(
   parameter int Q = 60
) (
   output logic scl_o,
   output logic sda_pull_o,
   input wire logic sda_i
);
   // bus parked: clock high, data released
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   // one bit: data set while clock low, sampled while high
   task automatic pulse(input logic pull, output logic seen);
      sda_pull_o = pull;
      #Q scl_o = 1'b1;
      #Q seen = sda_i;
      #Q scl_o = 1'b0;
      #Q;
   endtask
   // data falls while clock high
   task automatic start();
      #Q sda_pull_o = 1'b1;
      #Q scl_o = 1'b0;
      #Q;
   endtask
   // data rises while clock high
   task automatic stop();
      sda_pull_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q sda_pull_o = 1'b0;
      #Q;
   endtask
   // eight bits out, then the slave's answer
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) pulse(!b[i], s);
      pulse(1'b0, s);
      ack = !s;
   endtask
   // eight bits in, then our answer; last byte refused
   task automatic get_byte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         pulse(1'b0, s);
         b[i] = s;
      end
      pulse(!last, s);
   endtask
endmodule

// [test/test_mcu_two_wire_mailbox.sv]
// self-checking bench for the controller mailbox
// assumes the master model and the bound port checker
`timescale 1ns/1ns
module test_mcu_two_wire_mailbox;
   localparam int POLL = 200; // shortened report interval
   logic clk_i = 1'b0;
   logic link_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic report_ready_i = 1'b0;
   logic host_valid_i = 1'b0;
   mailbox_pkg::host_msg_t host_msg_i = '0;
   logic scl, pull, sda, sdo, oe, rep_v, h_rdy, pend; // pins and flags
   mailbox_pkg::in_report_t rep; // offered report
   int err_total = 0;
   int checks = 0;
   // core clock, 8 ns
   initial forever #4 clk_i = ~clk_i;
   // link clock, 6 ns, offset phase
   initial begin
      #2;
      forever #3 link_clk_i = ~link_clk_i;
   end
   // open-drain wire with pull-up
   assign sda = ~((oe & ~sdo) | pull);
   mcu_two_wire_mailbox #(.POLL_CYCLES(POLL)) u_mcu_two_wire_mailbox (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
      .serial_clock_i(scl), .serial_data_line_i(sda), .serial_data_line_o(sdo),
      .serial_data_line_oe_o(oe), .report_valid_o(rep_v), .report_ready_i(report_ready_i),
      .report_o(rep), .host_valid_i(host_valid_i), .host_ready_o(h_rdy),
      .host_msg_i(host_msg_i), .host_data_pending_flag_o(pend));
   mcu_master_model u_mcu_master_model (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda));
   // verdict and end of run
   task automatic stop_test();
      if (err_total == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // compare one value
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // bounded wait for a level
   task automatic wait_lvl(input string what, ref logic sig, input logic lvl, input int lim);
      int n = 0;
      while (sig !== lvl && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      chk(what, lvl, sig);
      if (sig !== lvl)
         stop_test();
   endtask
   // take one report and compare it
   task automatic get_report(input logic [23:0] exp);
      wait_lvl("report_valid_o", rep_v, 1'b1, 3 * POLL);
      chk("report_o", exp, rep);
      @(posedge clk_i);
      report_ready_i <= 1'b1;
      @(posedge clk_i);
      report_ready_i <= 1'b0;
      @(negedge clk_i);
   endtask
   // one word written: address, start address, low, high
   task automatic mcu_write(input logic [7:0] lo, input logic [7:0] hi, output logic ok);
      logic a;
      u_mcu_master_model.start();
      u_mcu_master_model.put_byte(8'h70, a);
      chk("write address ack", 1'b1, a);
      u_mcu_master_model.put_byte(8'h00, a);
      chk("start address ack", 1'b1, a);
      u_mcu_master_model.put_byte(lo, ok);
      if (ok) begin
         u_mcu_master_model.put_byte(hi, a);
         chk("high byte ack", 1'b1, a);
      end
      u_mcu_master_model.stop();
   endtask
   // a foreign address gets no acknowledge
   task automatic t_wrong_addr();
      logic a;
      u_mcu_master_model.start();
      u_mcu_master_model.put_byte(8'h72, a);
      chk("foreign address ack", 1'b0, a);
      u_mcu_master_model.stop();
   endtask
   // host bytes pend, refuse a second message, then are read back
   task automatic t_host_read();
      mailbox_pkg::host_msg_t m;
      logic [7:0] b;
      logic a;
      m = 32'h44332211;
      @(posedge clk_i);
      host_msg_i <= m;
      host_valid_i <= 1'b1;
      @(posedge clk_i);
      host_valid_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      chk("pending", 1'b1, pend);
      chk("host_ready_o", 1'b0, h_rdy);
      @(posedge clk_i);
      host_msg_i <= 32'h88776655;
      host_valid_i <= 1'b1;
      @(posedge clk_i);
      host_valid_i <= 1'b0;
      u_mcu_master_model.start();
      u_mcu_master_model.put_byte(8'h70, a);
      u_mcu_master_model.put_byte(8'h00, a);
      u_mcu_master_model.stop();
      u_mcu_master_model.start();
      u_mcu_master_model.put_byte(8'h71, a);
      chk("read address ack", 1'b1, a);
      for (int i = 0; i < mailbox_pkg::HOST_BYTES; i++) begin
         u_mcu_master_model.get_byte(i == mailbox_pkg::HOST_BYTES - 1, b);
         chk("read byte", m[i], b);
      end
      u_mcu_master_model.stop();
      wait_lvl("pending", pend, 1'b0, 20);
   endtask
   // fill the buffer with the host stalled, then drain in order
   task automatic t_fill_drain();
      logic ok;
      int n;
      n = 0;
      ok = 1'b1;
      get_report(24'h000000);
      while (ok && n < 20) begin
         mcu_write(8'h10 + n[7:0], 8'hA0 + n[7:0], ok);
         if (ok)
            n++;
      end
      chk("words accepted", mailbox_pkg::FIFO_DEPTH + 1, n);
      get_report(24'h000000);
      for (int k = 0; k < n; k++)
         get_report({8'hA0 + k[7:0], 8'h10 + k[7:0], 8'h80});
      get_report(24'h000000);
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      t_wrong_addr();
      t_host_read();
      t_fill_drain();
      stop_test();
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge clk_i);
      err_total++;
      stop_test();
   end
endmodule
